//--- core/sfs_pkg.sv
// Purpose: shared constants and types of the paper-feed step sequencer
// Assumes: 20 MHz system clock
// Notes: step times are held in microseconds and scaled to cycles in the controller
package sfs_pkg;

  localparam int CLK_HZ = 20000000;
  localparam int CLK_PER_US_DEF = CLK_HZ / 1000000;
  localparam int STOP_HOLD_US = 65000;
  localparam int START_HOLD_US = 4291;
  localparam int CNT_W = 24;
  localparam int US_W = 13;
  localparam int IDX_W = 7;
  localparam logic [IDX_W-1:0] ACC_LAST_IDX = 7'h51;
  // 926 pps is the fastest table rate still under the 960 pps reverse limit
  localparam logic [IDX_W-1:0] BACK_MAX_IDX = 7'h09;
  localparam logic [1:0] STEPS_PER_LINE_M1 = 2'h3;
  localparam logic [2:0] PHASE_RESET = 3'h0;

  // 81-step acceleration table
  // entry 0 is the start step, entry n the n-th acceleration step
  localparam logic [US_W-1:0] ACC_US_TBL [0:81] = '{
    13'd4291, 13'd4291, 13'd2652, 13'd2048, 13'd1719, 13'd1507, 13'd1357, 13'd1243,
    13'd1153, 13'd1080, 13'd1019, 13'd967, 13'd923, 13'd883, 13'd849, 13'd818,
    13'd790, 13'd765, 13'd742, 13'd721, 13'd702, 13'd684, 13'd668, 13'd652,
    13'd638, 13'd624, 13'd612, 13'd600, 13'd588, 13'd578, 13'd568, 13'd558,
    13'd549, 13'd540, 13'd532, 13'd524, 13'd516, 13'd509, 13'd502, 13'd495,
    13'd489, 13'd483, 13'd477, 13'd471, 13'd466, 13'd460, 13'd455, 13'd450,
    13'd445, 13'd440, 13'd436, 13'd432, 13'd427, 13'd423, 13'd419, 13'd415,
    13'd411, 13'd408, 13'd404, 13'd400, 13'd397, 13'd394, 13'd390, 13'd387,
    13'd384, 13'd381, 13'd378, 13'd375, 13'd372, 13'd370, 13'd367, 13'd364,
    13'd362, 13'd359, 13'd357, 13'd354, 13'd352, 13'd350, 13'd347, 13'd345,
    13'd343, 13'd341};

  typedef enum logic [1:0] {
    SFS_PAUSE = 2'b00,
    SFS_START = 2'b01,
    SFS_RUN = 2'b10,
    SFS_STOP = 2'b11
  } sfs_state_t;

  typedef struct packed {
    logic driverEnableLevel;
    logic phaseInD;
    logic phaseInC;
    logic phaseInB;
    logic phaseInA;
  } sfs_pins_t;

  // phase pattern {d,c,b,a} for steps 1..8 at index 0..7
  function automatic logic [3:0] phasePattern(input logic [2:0] idx);
    case (idx)
      3'h0: phasePattern = 4'h1;
      3'h1: phasePattern = 4'h9;
      3'h2: phasePattern = 4'h8;
      3'h3: phasePattern = 4'ha;
      3'h4: phasePattern = 4'h2;
      3'h5: phasePattern = 4'h6;
      3'h6: phasePattern = 4'h4;
      3'h7: phasePattern = 4'h5;
      default: phasePattern = 4'h0;
    endcase
  endfunction

endpackage

//--- core/sfs_ctrl.sv
// Purpose: host-side sequencer driving the four motor phase pins and the driver enable
// Assumes: command inputs come from logic on clk_sys; pins are plain outputs
// Notes: user picks the speed cap from the drive voltage; long holds shrink via CLK_PER_US
`timescale 1ns/1ps
`default_nettype none
module sfs_ctrl
  import sfs_pkg::*;
#(
  parameter int CLK_PER_US = CLK_PER_US_DEF
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic startReq,
  input wire logic stopReq,
  input wire logic dirBack,
  input wire logic [IDX_W-1:0] capIdx,
  input wire logic slowReq,
  input wire logic [US_W-1:0] slowUs,
  output var sfs_pins_t pins,
  output logic busy,
  output logic stepPulse,
  output logic lineDone,
  output logic [IDX_W-1:0] stepIdx
);

  if (CLK_PER_US < 1 || CLK_PER_US > 255)
  begin : g_bad_rate
    $error("CLK_PER_US must be 1..255");
  end

  function automatic logic [CNT_W-1:0] usToCyc(input logic [16:0] us);
    usToCyc = CNT_W'(us) * CNT_W'(CLK_PER_US);
  endfunction

  // largest index whose time is still longer than us; index 1 if none
  function automatic logic [IDX_W-1:0] reaccelIdx(input logic [US_W-1:0] us);
    reaccelIdx = 7'h01;
    for (int i = 1; i <= 81; i++)
    begin
      if (ACC_US_TBL[i] > us)
      begin
        reaccelIdx = IDX_W'(i);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  sfs_state_t state_r;
  sfs_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [2:0] phaseIdx_r;
  logic [2:0] phaseIdx_nxt;
  logic [IDX_W-1:0] idx_r;
  logic [IDX_W-1:0] idx_nxt;
  logic [US_W-1:0] curUs_r;
  logic [US_W-1:0] curUs_nxt;
  logic slowed_r;
  logic slowed_nxt;
  logic dirBack_r;
  logic [1:0] lineCnt_r;
  logic lineDone_r;
  logic stepPulse_r;
  logic [IDX_W-1:0] capEff;
  logic expire;
  logic advance;
  logic dirEff;

  assign expire = (cnt_r == CNT_W'(1));
  // a restart from the stop step takes its new direction on that very step
  assign dirEff = (state_r == SFS_STOP && startReq) ? dirBack : dirBack_r;

  always_comb
  begin
    capEff = capIdx;
    if (capIdx == '0)
    begin
      capEff = 7'h01;
    end
    else if (capIdx > ACC_LAST_IDX)
    begin
      capEff = ACC_LAST_IDX;
    end
    if (dirBack_r && capEff > BACK_MAX_IDX)
    begin
      capEff = BACK_MAX_IDX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r > CNT_W'(1)) ? cnt_r - CNT_W'(1) : cnt_r;
    idx_nxt = idx_r;
    curUs_nxt = curUs_r;
    slowed_nxt = slowed_r;
    advance = 1'b0;
    case (state_r)
      SFS_PAUSE:
      begin
        if (startReq)
        begin
          // hold old phase for start step
          state_nxt = SFS_START;
          cnt_nxt = usToCyc(17'(START_HOLD_US));
          idx_nxt = '0;
        end
      end
      SFS_START:
      begin
        if (stopReq)
        begin
          state_nxt = SFS_STOP;
          cnt_nxt = usToCyc(17'(STOP_HOLD_US));
        end
        else if (expire)
        begin
          state_nxt = SFS_RUN;
          advance = 1'b1;
          idx_nxt = 7'h01;
          curUs_nxt = ACC_US_TBL[1];
          slowed_nxt = 1'b0;
          cnt_nxt = usToCyc(17'(ACC_US_TBL[1]));
        end
      end
      SFS_RUN:
      begin
        if (stopReq)
        begin
          // keep last phase for the stop hold
          state_nxt = SFS_STOP;
          cnt_nxt = usToCyc(17'(STOP_HOLD_US));
        end
        else if (expire)
        begin
          advance = 1'b1;
          if (slowReq)
          begin
            curUs_nxt = slowUs;
            slowed_nxt = 1'b1;
          end
          else
          begin
            if (slowed_r)
            begin
              // resume just slower than the last step
              idx_nxt = reaccelIdx(curUs_r);
            end
            else if (idx_r < capEff)
            begin
              idx_nxt = idx_r + 7'h01;
            end
            if (idx_nxt > capEff)
            begin
              idx_nxt = capEff;
            end
            slowed_nxt = 1'b0;
            curUs_nxt = ACC_US_TBL[idx_nxt];
          end
          cnt_nxt = usToCyc(17'(curUs_nxt));
        end
      end
      SFS_STOP:
      begin
        if (startReq)
        begin
          state_nxt = SFS_RUN;
          advance = 1'b1;
          idx_nxt = 7'h01;
          curUs_nxt = ACC_US_TBL[1];
          slowed_nxt = 1'b0;
          cnt_nxt = usToCyc(17'(ACC_US_TBL[1]));
        end
        else if (expire)
        begin
          state_nxt = SFS_PAUSE;
        end
      end
      default:
      begin
        state_nxt = SFS_PAUSE;
      end
    endcase
  end

  always_comb
  begin
    phaseIdx_nxt = phaseIdx_r;
    if (advance)
    begin
      phaseIdx_nxt = dirEff ? phaseIdx_r - 3'h1 : phaseIdx_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= SFS_PAUSE;
      cnt_r <= '0;
      idx_r <= '0;
      curUs_r <= '0;
      slowed_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      curUs_r <= curUs_nxt;
      slowed_r <= slowed_nxt;
    end
  end

  // direction only changes while not stepping
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dirBack_r <= 1'b0;
    end
    else if (startReq && (state_r == SFS_PAUSE || state_r == SFS_STOP))
    begin
      dirBack_r <= dirBack;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phaseIdx_r <= PHASE_RESET;
      lineCnt_r <= '0;
      lineDone_r <= 1'b0;
      stepPulse_r <= 1'b0;
    end
    else
    begin
      phaseIdx_r <= phaseIdx_nxt;
      stepPulse_r <= advance;
      lineDone_r <= advance && (lineCnt_r == STEPS_PER_LINE_M1);
      if (advance)
      begin
        lineCnt_r <= lineCnt_r + 2'h1;
      end
    end
  end

  // registered pins, dark and disabled in pause
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins <= '0;
    end
    else if (state_nxt == SFS_PAUSE)
    begin
      pins <= '0;
    end
    else
    begin
      pins <= {1'b1, phasePattern(phaseIdx_nxt)};
    end
  end

  // printing may run off these strobes at any speed
  assign busy = (state_r != SFS_PAUSE);
  assign stepPulse = stepPulse_r;
  assign lineDone = lineDone_r;
  assign stepIdx = idx_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence enterStop;
    (state_r == SFS_RUN) && stopReq;
  endsequence
  sequence runStep;
    (state_r == SFS_RUN) && expire && !stopReq && !slowReq && !slowed_r;
  endsequence

  chk_pause_dark: assert property ((state_r == SFS_PAUSE) && !$past(startReq) |-> pins == '0)
    else $error("pins active in pause");
  chk_enable_drive: assert property (pins[3:0] != 4'h0 |-> pins.driverEnableLevel)
    else $error("phase driven without enable");
  chk_pattern_legal: assert property (busy |-> pins[3:0] == phasePattern(phaseIdx_r))
    else $error("illegal phase pattern");
  chk_fwd_order: assert property (stepPulse && !dirBack_r |-> phaseIdx_r == $past(phaseIdx_r) + 3'h1)
    else $error("forward order broken");
  chk_back_order: assert property (stepPulse && dirBack_r |-> phaseIdx_r == $past(phaseIdx_r) - 3'h1)
    else $error("backward order broken");
  chk_stop_entry: assert property (enterStop |=> $stable(pins))
    else $error("phase moved entering stop hold");
  chk_stop_hold: assert property ((state_r == SFS_STOP) && !startReq && !expire |=> $stable(pins))
    else $error("phase moved during stop hold");
  chk_stop_len: assert property (enterStop |=> cnt_r == usToCyc(17'(STOP_HOLD_US)))
    else $error("stop hold length wrong");
  chk_start_hold: assert property ((state_r == SFS_PAUSE) && startReq |=> (state_r == SFS_START) && cnt_r == usToCyc(17'(START_HOLD_US)) && phaseIdx_r == $past(phaseIdx_r))
    else $error("start step wrong");
  chk_restart_direct: assert property ((state_r == SFS_STOP) && startReq |=> (state_r == SFS_RUN) && stepPulse)
    else $error("restart not direct");
  chk_accel_next: assert property (runStep ##0 (idx_r < capEff) |=> idx_r == $past(idx_r) + 7'h01 && cnt_r == usToCyc(17'(ACC_US_TBL[idx_r])))
    else $error("acceleration step skipped");
  chk_back_cap: assert property ((state_r == SFS_RUN) && dirBack_r |-> idx_r <= BACK_MAX_IDX)
    else $error("reverse rate above limit");
  chk_line_pulse: assert property (lineDone |-> stepPulse && lineCnt_r == 2'h0)
    else $error("line pulse misplaced");

endmodule
`default_nettype wire

//--- bench/sfs_motor_model.sv
// Purpose: behavioural feed motor watching the sequencer's phase pins
// Assumes: pins are registered on clk_sys
// Notes: counts feed in whole steps; missed steps are not modelled
`timescale 1ns/1ps
`default_nettype none
module sfs_motor_model
  import sfs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire sfs_pins_t pins,
  output logic signed [31:0] feedSteps
);
  localparam logic [3:0] ROTOR [0:7] = '{4'h1, 4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4, 4'h5};
  logic [2:0] rotorPos_r;
  int seen;
  always_comb
  begin
    seen = -1;
    for (int i = 0; i < 8; i++)
      if (pins[3:0] == ROTOR[i])
        seen = i;
  end
  ////////////////////////////////////////////////////////////////
  // feed per step, unexcited holds
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      feedSteps <= '0;
      rotorPos_r <= 3'h0;
    end
    else if (pins.driverEnableLevel && seen >= 0)
    begin
      rotorPos_r <= 3'(seen);
      if (3'(seen) == rotorPos_r + 3'h1)
        feedSteps <= feedSteps + 1;
      else if (3'(seen) == rotorPos_r - 3'h1)
        feedSteps <= feedSteps - 1;
    end
  end
endmodule
`default_nettype wire

//--- bench/stepper_feed_sequencer_test.sv
// Purpose: self-checking bench of the feed sequencer
// Assumes: CLK_PER_US=1, so one table microsecond is one cycle
// Notes: about 110k cycles, dominated by the stop hold
`timescale 1ns/1ps
`default_nettype none
module stepper_feed_sequencer_test
  import sfs_pkg::*;
;
  localparam logic [3:0] PAT [0:7] = '{4'h1, 4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4, 4'h5};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic startReq = 1'b0;
  logic stopReq = 1'b0;
  logic dirBack = 1'b0;
  logic [IDX_W-1:0] capIdx = 7'h03;
  logic slowReq = 1'b0;
  logic [US_W-1:0] slowUs = 13'h0;
  sfs_pins_t pins;
  logic busy;
  logic stepPulse;
  logic lineDone;
  logic [IDX_W-1:0] stepIdx;
  logic signed [31:0] feedSteps;
  int ph = 0;
  int nSteps = 0;
  int expFeed = 0;
  int cycles = 0;
  int lastP = 0;
  int n_errors = 0;
  int n_compared = 0;

  always #25 clk_sys = ~clk_sys;

  sfs_ctrl #(.CLK_PER_US(1)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .startReq(startReq),
    .stopReq(stopReq), .dirBack(dirBack), .capIdx(capIdx), .slowReq(slowReq),
    .slowUs(slowUs), .pins(pins), .busy(busy), .stepPulse(stepPulse), .lineDone(lineDone),
    .stepIdx(stepIdx));
  sfs_motor_model model (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .feedSteps(feedSteps));

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, well above the planned run
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 130000)
    begin
      n_errors++;
      complete_run();
    end
  end

  task automatic cmd(input logic go);
    @(posedge clk_sys);
    startReq <= go;
    stopReq <= !go;
    @(posedge clk_sys);
    startReq <= 1'b0;
    stopReq <= 1'b0;
    @(negedge clk_sys);
    lastP = cycles;
  endtask

  task automatic stepSeen();
    nSteps++;
    expFeed += dirBack ? -1 : 1;
    ph = dirBack ? (ph + 7) % 8 : (ph + 1) % 8;
    check(pins, {1'b1, PAT[ph]});
    check(lineDone, nSteps % 4 == 0);
  endtask

  // step length is measured between pulses, not assumed
  task automatic nextStep(input int expLen);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (stepPulse !== 1'b1 && n < 70000);
    check(cycles - lastP, expLen);
    lastP = cycles;
    stepSeen();
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic testForward();
    check(pins, 5'h00);
    check(busy, 1'b0);
    cmd(1'b1);
    check(pins, {1'b1, PAT[0]});
    nextStep(4291);
    nextStep(4291);
    nextStep(2652);
    nextStep(2048);
    nextStep(2048);
    check(stepIdx, 7'h03);
  endtask

  task automatic testSlow();
    @(posedge clk_sys);
    slowUs <= 13'h9c4;
    slowReq <= 1'b1;
    nextStep(2048);
    @(posedge clk_sys);
    slowReq <= 1'b0;
    nextStep(2500);
    // resumed step is the one just slower than the slowed step
    check(stepIdx, 7'h02);
    nextStep(2652);
    nextStep(2048);
  endtask

  task automatic testBack();
    int lens [0:9] = '{4291, 2652, 2048, 1719, 1507, 1357, 1243, 1153, 1080, 1080};
    @(posedge clk_sys);
    capIdx <= 7'h51;
    cmd(1'b0);
    repeat (3) @(negedge clk_sys);
    check(pins, {1'b1, PAT[ph]});
    check(feedSteps, expFeed);
    @(posedge clk_sys);
    dirBack <= 1'b1;
    cmd(1'b1);
    check(stepPulse, 1'b1);
    check(stepIdx, 7'h01);
    stepSeen();
    foreach (lens[i])
      nextStep(lens[i]);
    check(stepIdx, 7'h09);
  endtask

  task automatic testStop();
    sfs_pins_t held;
    int n;
    cmd(1'b0);
    n = 0;
    held = pins;
    // pins go dark on the same edge that ends the hold, so keep the last held view
    while (busy === 1'b1 && n < 70000)
    begin
      held = pins;
      @(negedge clk_sys);
      n++;
    end
    check(cycles - lastP, 65000);
    check(held, {1'b1, PAT[ph]});
    check(feedSteps, expFeed);
    @(negedge clk_sys);
    check(pins, 5'h00);
    @(posedge clk_sys);
    dirBack <= 1'b0;
    cmd(1'b1);
    check(pins, {1'b1, PAT[ph]});
  endtask

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    testForward();
    testSlow();
    testBack();
    testStop();
    complete_run();
  end
endmodule
`default_nettype wire
